// File: verilog/iss_consts.svh
// Summary of operation
// - select lines pick presets one, two, three
// - direction line off forward, on reverse
// - no select: ramp down, then hold
// - selection works only with enable bit set
// - mode 00: servo-lock at zero, no analog
// - mode 01: position-lock below threshold, no analog
// - mode 10: servo-lock, analog accepted when idle
// - mode 11: position-lock, analog accepted when idle
// - never active in torque control
// - three presets 0..4500, defaults 100/200/300
// - ramp-down time 0..10000 ms, default 0
// - speed match within band 0..100, default 10
// - hold gain 1..500, default 40
// - ramp times scale by speed over 4500
// - lock threshold 0..4500, default 10
// - inputs acted on within 6 ms
`ifndef ISS_CONSTS_SVH
`define ISS_CONSTS_SVH
`define ISS_OFF_SETUP1 8'h00
`define ISS_OFF_SETUP2 8'h04
`define ISS_OFF_LOCK_THR 8'h08
`define ISS_OFF_RAMP_UP 8'h0C
`define ISS_OFF_GAIN 8'h10
`define ISS_OFF_PRESET1 8'h14
`define ISS_OFF_PRESET2 8'h18
`define ISS_OFF_PRESET3 8'h1C
`define ISS_OFF_BAND 8'h20
`define ISS_OFF_RAMP_DN 8'h24
`define ISS_OFF_STATUS 8'h28
`define ISS_BIT_TORQUE 0
`define ISS_BIT_SEL_EN 2
`define ISS_BIT_MODE_A 10
`define ISS_BIT_MODE_B 11
`define ISS_RST_SETUP 16'h0000
`define ISS_RST_LOCK_THR 16'h000A
`define ISS_RST_RAMP 16'h0000
`define ISS_RST_GAIN 16'h0028
`define ISS_RST_PRESET1 16'h0064
`define ISS_RST_PRESET2 16'h00C8
`define ISS_RST_PRESET3 16'h012C
`define ISS_RST_BAND 16'h000A
`define ISS_FULL_SCALE 16'h1194
`define ISS_MAX_TIME 16'h2710
`define ISS_MAX_BAND 16'h0064
`define ISS_MIN_GAIN 16'h0001
`define ISS_MAX_GAIN 16'h01F4
`define ISS_ZERO16 16'h0000
`define ISS_CLK_HZ 25000000
`define ISS_HZ_PER_KHZ 1000
`define ISS_SAMPLE_MAX_MS 6
`define ISS_SAMPLE_PIPE 4
`endif

// File: verilog/iss_pkg.sv
package iss_pkg;
    typedef enum logic [1:0] {
        ISS_RUN = 2'b00,
        ISS_STOPPING = 2'b01,
        ISS_SERVO_HOLD = 2'b10,
        ISS_POS_HOLD = 2'b11
    } iss_state_t;
    typedef enum logic [1:0] {
        ISS_SEL_NONE = 2'b00,
        ISS_SEL_ONE = 2'b01,
        ISS_SEL_TWO = 2'b10,
        ISS_SEL_THREE = 2'b11
    } iss_sel_t;
endpackage : iss_pkg

// File: verilog/iss_top.sv
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "iss_consts.svh"
module iss_top
    import iss_pkg::*;
#(
    parameter int CYC_PER_MS = `ISS_CLK_HZ / `ISS_HZ_PER_KHZ,
    parameter int DEB_CYC = `ISS_SAMPLE_MAX_MS * (`ISS_CLK_HZ / `ISS_HZ_PER_KHZ) - `ISS_SAMPLE_PIPE
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SPEED_SELECT_LO,
    input wire logic SPEED_SELECT_HI,
    input wire logic DIRECTION_SELECT,
    input wire logic signed [15:0] ANALOG_CMD,
    input wire logic signed [15:0] ACTUAL_SPEED,
    output logic signed [15:0] SPEED_CMD,
    output logic SELECT_ACTIVE,
    output logic SERVO_LOCK,
    output logic POS_LOOP_EN,
    output logic SPEED_MATCH,
    output logic [15:0] HOLD_GAIN
);

    function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [15:0] lo, input logic [15:0] hi);
        logic [15:0] r;
        r = v[15:0];
        if (v > {16'h0000, hi}) begin
            r = hi;
        end else if (v < {16'h0000, lo}) begin
            r = lo;
        end
        return r;
    endfunction : clamp16

    function automatic logic [15:0] mag16(input logic signed [15:0] v);
        logic [15:0] r;
        r = v[15] ? 16'(-v) : 16'(v);
        return r;
    endfunction : mag16

    function automatic iss_sel_t decode_sel(input logic lo, input logic hi);
        iss_sel_t r;
        r = ISS_SEL_NONE;
        if (!lo && hi) begin
            r = ISS_SEL_ONE;
        end else if (lo && hi) begin
            r = ISS_SEL_TWO;
        end else if (lo && !hi) begin
            r = ISS_SEL_THREE;
        end
        return r;
    endfunction : decode_sel

    logic [15:0] setup1_ff, setup2_ff, lock_thr_ff, ramp_up_ff, gain_ff;
    logic [15:0] preset1_ff, preset2_ff, preset3_ff, band_ff, ramp_dn_ff;
    logic [15:0] nxt_setup1, nxt_setup2, nxt_lock_thr, nxt_ramp_up, nxt_gain;
    logic [15:0] nxt_preset1, nxt_preset2, nxt_preset3, nxt_band, nxt_ramp_dn;
    logic [31:0] prdata_ff, nxt_prdata, rd_data;
    logic pslverr_ff, nxt_pslverr, rd_hit;
    logic wr_en, setup_phase;
    logic [2:0] sync1_ff, sync2_ff, cand_ff, stable_ff;
    logic [2:0] nxt_cand, nxt_stable;
    logic [17:0] deb_cnt_ff, nxt_deb_cnt;
    iss_state_t state_ff, nxt_state;
    logic signed [15:0] cmd_ff, nxt_cmd, target;
    logic [31:0] err_ff, nxt_err, err_sum, denom;
    logic servo_ff, nxt_servo, pos_ff, nxt_pos, match_ff, nxt_match;
    logic active, analog_ok, mode_a, mode_b, dir_rev, accel;
    logic [15:0] preset_sel, gap;
    iss_sel_t sel;

    assign setup_phase = PSEL && !PENABLE;
    assign wr_en = PSEL && PENABLE && PWRITE;
    assign PREADY = 1'b1;
    assign PRDATA = prdata_ff;
    assign PSLVERR = pslverr_ff;

    // write path; out-of-range values are clamped so the ramp math never sees them
    always_comb begin
        nxt_setup1 = setup1_ff;
        nxt_setup2 = setup2_ff;
        nxt_lock_thr = lock_thr_ff;
        nxt_ramp_up = ramp_up_ff;
        nxt_gain = gain_ff;
        nxt_preset1 = preset1_ff;
        nxt_preset2 = preset2_ff;
        nxt_preset3 = preset3_ff;
        nxt_band = band_ff;
        nxt_ramp_dn = ramp_dn_ff;
        if (wr_en) begin
            unique case (PADDR)
                `ISS_OFF_SETUP1: nxt_setup1 = PWDATA[15:0];
                `ISS_OFF_SETUP2: nxt_setup2 = PWDATA[15:0];
                `ISS_OFF_LOCK_THR: nxt_lock_thr = clamp16(PWDATA, `ISS_ZERO16, `ISS_FULL_SCALE);
                `ISS_OFF_RAMP_UP: nxt_ramp_up = clamp16(PWDATA, `ISS_ZERO16, `ISS_MAX_TIME);
                `ISS_OFF_GAIN: nxt_gain = clamp16(PWDATA, `ISS_MIN_GAIN, `ISS_MAX_GAIN);
                `ISS_OFF_PRESET1: nxt_preset1 = clamp16(PWDATA, `ISS_ZERO16, `ISS_FULL_SCALE);
                `ISS_OFF_PRESET2: nxt_preset2 = clamp16(PWDATA, `ISS_ZERO16, `ISS_FULL_SCALE);
                `ISS_OFF_PRESET3: nxt_preset3 = clamp16(PWDATA, `ISS_ZERO16, `ISS_FULL_SCALE);
                `ISS_OFF_BAND: nxt_band = clamp16(PWDATA, `ISS_ZERO16, `ISS_MAX_BAND);
                `ISS_OFF_RAMP_DN: nxt_ramp_dn = clamp16(PWDATA, `ISS_ZERO16, `ISS_MAX_TIME);
                default: nxt_setup1 = setup1_ff;
            endcase
        end
    end

    // read data is captured in the setup cycle so it stands from a flop during access
    always_comb begin
        rd_data = 32'h00000000;
        rd_hit = 1'b1;
        unique case (PADDR)
            `ISS_OFF_SETUP1: rd_data[15:0] = setup1_ff;
            `ISS_OFF_SETUP2: rd_data[15:0] = setup2_ff;
            `ISS_OFF_LOCK_THR: rd_data[15:0] = lock_thr_ff;
            `ISS_OFF_RAMP_UP: rd_data[15:0] = ramp_up_ff;
            `ISS_OFF_GAIN: rd_data[15:0] = gain_ff;
            `ISS_OFF_PRESET1: rd_data[15:0] = preset1_ff;
            `ISS_OFF_PRESET2: rd_data[15:0] = preset2_ff;
            `ISS_OFF_PRESET3: rd_data[15:0] = preset3_ff;
            `ISS_OFF_BAND: rd_data[15:0] = band_ff;
            `ISS_OFF_RAMP_DN: rd_data[15:0] = ramp_dn_ff;
            `ISS_OFF_STATUS: rd_data = {cmd_ff, 11'h000, pos_ff, match_ff, active, state_ff};
            default: rd_hit = 1'b0;
        endcase
        nxt_prdata = setup_phase ? rd_data : prdata_ff;
        nxt_pslverr = setup_phase ? !rd_hit : pslverr_ff;
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            setup1_ff <= `ISS_RST_SETUP;
            setup2_ff <= `ISS_RST_SETUP;
            lock_thr_ff <= `ISS_RST_LOCK_THR;
            ramp_up_ff <= `ISS_RST_RAMP;
            gain_ff <= `ISS_RST_GAIN;
            preset1_ff <= `ISS_RST_PRESET1;
            preset2_ff <= `ISS_RST_PRESET2;
            preset3_ff <= `ISS_RST_PRESET3;
            band_ff <= `ISS_RST_BAND;
            ramp_dn_ff <= `ISS_RST_RAMP;
            prdata_ff <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end else begin
            setup1_ff <= nxt_setup1;
            setup2_ff <= nxt_setup2;
            lock_thr_ff <= nxt_lock_thr;
            ramp_up_ff <= nxt_ramp_up;
            gain_ff <= nxt_gain;
            preset1_ff <= nxt_preset1;
            preset2_ff <= nxt_preset2;
            preset3_ff <= nxt_preset3;
            band_ff <= nxt_band;
            ramp_dn_ff <= nxt_ramp_dn;
            prdata_ff <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // a code must stay steady for DEB_CYC cycles; total lag stays within 6 ms
    always_comb begin
        nxt_cand = cand_ff;
        nxt_stable = stable_ff;
        nxt_deb_cnt = deb_cnt_ff;
        if (sync2_ff != cand_ff) begin
            nxt_cand = sync2_ff;
            nxt_deb_cnt = 18'h00000;
        end else if (deb_cnt_ff >= 18'(DEB_CYC)) begin
            nxt_stable = cand_ff;
        end else begin
            nxt_deb_cnt = deb_cnt_ff + 18'h00001;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
            cand_ff <= 3'h0;
            stable_ff <= 3'h0;
            deb_cnt_ff <= 18'h00000;
        end else begin
            sync1_ff <= {DIRECTION_SELECT, SPEED_SELECT_HI, SPEED_SELECT_LO};
            sync2_ff <= sync1_ff;
            cand_ff <= nxt_cand;
            stable_ff <= nxt_stable;
            deb_cnt_ff <= nxt_deb_cnt;
        end
    end

    assign active = setup2_ff[`ISS_BIT_SEL_EN] && !setup1_ff[`ISS_BIT_TORQUE];
    assign mode_a = setup1_ff[`ISS_BIT_MODE_A];
    assign mode_b = setup1_ff[`ISS_BIT_MODE_B];
    assign sel = decode_sel(stable_ff[0], stable_ff[1]);
    assign dir_rev = stable_ff[2];
    // with the selector active, analog input only counts in the b=1 modes and only while no preset is selected
    assign analog_ok = mode_b && (sel == ISS_SEL_NONE);

    always_comb begin
        preset_sel = `ISS_ZERO16;
        unique case (sel)
            ISS_SEL_NONE: preset_sel = `ISS_ZERO16;
            ISS_SEL_ONE: preset_sel = preset1_ff;
            ISS_SEL_TWO: preset_sel = preset2_ff;
            ISS_SEL_THREE: preset_sel = preset3_ff;
        endcase
        if (sel != ISS_SEL_NONE) begin
            target = dir_rev ? -$signed(preset_sel) : $signed(preset_sel);
        end else if (analog_ok) begin
            target = ANALOG_CMD;
        end else begin
            target = $signed(`ISS_ZERO16);
        end
    end

    // hold state machine
    always_comb begin
        nxt_state = state_ff;
        if (!active) begin
            nxt_state = ISS_RUN;
        end else begin
            unique case (state_ff)
                ISS_RUN: if (sel == ISS_SEL_NONE) begin
                    nxt_state = ISS_STOPPING;
                end
                // position-lock only while stopping toward zero; a live analog
                // target would otherwise bounce the state every cycle
                ISS_STOPPING: if (sel != ISS_SEL_NONE) begin
                    nxt_state = ISS_RUN;
                end else if (mode_a && (target == $signed(`ISS_ZERO16)) && (mag16(ACTUAL_SPEED) < lock_thr_ff)) begin
                    nxt_state = ISS_POS_HOLD;
                end else if (!mode_a && (cmd_ff == target) && (target == $signed(`ISS_ZERO16))) begin
                    nxt_state = ISS_SERVO_HOLD;
                end
                ISS_SERVO_HOLD, ISS_POS_HOLD: if ((sel != ISS_SEL_NONE) || (target != $signed(`ISS_ZERO16))) begin
                    nxt_state = ISS_STOPPING;
                end
            endcase
        end
        nxt_servo = active && (nxt_state == ISS_SERVO_HOLD);
        nxt_pos = active && (nxt_state == ISS_POS_HOLD);
    end

    // ramp: one count step whenever the error sum passes time*cycles-per-ms,
    // so full scale takes exactly the set time and smaller moves scale down
    always_comb begin
        accel = ((target > cmd_ff) && !cmd_ff[15]) || ((target < cmd_ff) && (cmd_ff[15] || cmd_ff == 16'sh0000));
        denom = 32'(accel ? ramp_up_ff : ramp_dn_ff) * 32'(CYC_PER_MS);
        err_sum = err_ff + 32'(`ISS_FULL_SCALE);
        nxt_err = 32'h00000000;
        nxt_cmd = cmd_ff;
        if (!active) begin
            nxt_cmd = ANALOG_CMD;
        end else if (cmd_ff != target) begin
            if (denom == 32'h00000000) begin
                nxt_cmd = target;
            end else if (err_sum >= denom) begin
                nxt_err = err_sum - denom;
                nxt_cmd = (target > cmd_ff) ? cmd_ff + 16'sh0001 : cmd_ff - 16'sh0001;
            end else begin
                nxt_err = err_sum;
            end
        end
        gap = mag16(ACTUAL_SPEED - cmd_ff);
        nxt_match = gap <= band_ff;
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state_ff <= ISS_RUN;
            cmd_ff <= 16'sh0000;
            err_ff <= 32'h00000000;
            servo_ff <= 1'b0;
            pos_ff <= 1'b0;
            match_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cmd_ff <= nxt_cmd;
            err_ff <= nxt_err;
            servo_ff <= nxt_servo;
            pos_ff <= nxt_pos;
            match_ff <= nxt_match;
        end
    end

    assign SPEED_CMD = cmd_ff;
    assign SELECT_ACTIVE = active;
    assign SERVO_LOCK = servo_ff;
    assign POS_LOOP_EN = pos_ff;
    assign SPEED_MATCH = match_ff;
    assign HOLD_GAIN = gain_ff;

endmodule : iss_top
`default_nettype wire

// File: bench/iss_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module iss_ctrl_model (
    input wire logic clk,
    input wire logic [2:0] req,
    output logic sel_lo,
    output logic sel_hi,
    output logic dir
);
    initial {dir, sel_hi, sel_lo} = 3'h0;
    // all lines switch on one edge, so no stray code is ever seen
    always @(posedge clk) begin
        {dir, sel_hi, sel_lo} <= req;
    end
endmodule : iss_ctrl_model
`default_nettype wire

// File: bench/iss_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module iss_monitor (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PSLVERR,
    input wire logic signed [15:0] ANALOG_CMD,
    input wire logic signed [15:0] ACTUAL_SPEED,
    input wire logic signed [15:0] SPEED_CMD,
    input wire logic SELECT_ACTIVE,
    input wire logic SERVO_LOCK,
    input wire logic POS_LOOP_EN,
    input wire logic [15:0] HOLD_GAIN
);
    logic [15:0] thr_ff;
    logic [15:0] nxt_thr;
    logic [15:0] spd_mag;
    // software copy of the lock threshold, clamped the same way on write
    always_comb begin
        nxt_thr = thr_ff;
        if (PSEL && PENABLE && PWRITE && PADDR == 8'h08) begin
            nxt_thr = (PWDATA > 32'h00001194) ? 16'h1194 : PWDATA[15:0];
        end
        spd_mag = ACTUAL_SPEED[15] ? 16'(-ACTUAL_SPEED) : 16'(ACTUAL_SPEED);
    end
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            thr_ff <= 16'h000A;
        end else begin
            thr_ff <= nxt_thr;
        end
    end
    default clocking dc @(posedge CLOCK); endclocking
    default disable iff (RST);
    sequence s_acc;
        PSEL && PENABLE;
    endsequence
    sequence s_gain_wr;
        s_acc ##0 PWRITE && PADDR == 8'h10;
    endsequence
    sequence s_idle;
        !SELECT_ACTIVE && !$past(SELECT_ACTIVE) && !$past(RST);
    endsequence
    property p_unmapped;
        s_acc ##0 PADDR > 8'h28 |-> PSLVERR && PRDATA == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_gain;
        s_gain_wr ##0 PWDATA[31:16] == 16'h0000 && PWDATA[15:0] >= 16'h0001 && PWDATA[15:0] <= 16'h01F4
            |=> HOLD_GAIN == $past(PWDATA[15:0]);
    endproperty
    a_gain: assert property (p_gain) else $error("hold gain not updated");
    property p_gain_min;
        s_gain_wr ##0 PWDATA[15:0] == 16'h0000 |=> HOLD_GAIN == 16'h0001;
    endproperty
    a_gain_min: assert property (p_gain_min) else $error("hold gain below one");
    property p_follow;
        s_idle |-> SPEED_CMD == $past(ANALOG_CMD);
    endproperty
    a_follow: assert property (p_follow) else $error("analog not followed while inactive");
    property p_idle_nolock;
        s_idle |-> !SERVO_LOCK && !POS_LOOP_EN;
    endproperty
    a_idle_nolock: assert property (p_idle_nolock) else $error("hold while inactive");
    property p_excl;
        !(SERVO_LOCK && POS_LOOP_EN);
    endproperty
    a_excl: assert property (p_excl) else $error("both holds at once");
    property p_servo_zero;
        SERVO_LOCK |-> SPEED_CMD == 16'sh0000;
    endproperty
    a_servo_zero: assert property (p_servo_zero) else $error("servo hold at nonzero speed");
    property p_pos_slow;
        $rose(POS_LOOP_EN) |-> $past(spd_mag) < $past(thr_ff);
    endproperty
    a_pos_slow: assert property (p_pos_slow) else $error("position hold at high speed");
endmodule : iss_monitor
bind iss_top iss_monitor u_mon (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .ANALOG_CMD(ANALOG_CMD),
    .ACTUAL_SPEED(ACTUAL_SPEED), .SPEED_CMD(SPEED_CMD), .SELECT_ACTIVE(SELECT_ACTIVE),
    .SERVO_LOCK(SERVO_LOCK), .POS_LOOP_EN(POS_LOOP_EN), .HOLD_GAIN(HOLD_GAIN));
`default_nettype wire

// File: bench/test_internal_speed_selector.sv
`timescale 1ns/1ps
`default_nettype none
module test_internal_speed_selector
    import iss_pkg::*;
;
    localparam logic [7:0] RA [8] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};
    localparam logic [31:0] RV [8] = '{32'h0A, 32'h00, 32'h28, 32'h64, 32'hC8, 32'h12C, 32'h0A, 32'h00};
    localparam logic signed [15:0] PV [3] = '{16'sh0064, 16'sh00C8, 16'sh012C};
    localparam logic [1:0] CD [3] = '{2'b10, 2'b11, 2'b01};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic signed [15:0] analog = 16'sh0000;
    logic signed [15:0] actual = 16'sh0000;
    logic signed [15:0] cmd;
    logic [2:0] req = 3'h0;
    logic s_lo;
    logic s_hi;
    logic s_dir;
    logic act;
    logic slock;
    logic plock;
    logic match;
    logic [15:0] gain;
    logic [31:0] rd;
    logic er;
    int fail_count = 0;
    int samples_checked = 0;
    always #20 clk = ~clk;
    iss_ctrl_model u_ctl (.clk(clk), .req(req), .sel_lo(s_lo), .sel_hi(s_hi), .dir(s_dir));
    iss_top #(.CYC_PER_MS(10), .DEB_CYC(8)) u_dut (.CLOCK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .SPEED_SELECT_LO(s_lo), .SPEED_SELECT_HI(s_hi), .DIRECTION_SELECT(s_dir), .ANALOG_CMD(analog),
        .ACTUAL_SPEED(actual), .SPEED_CMD(cmd), .SELECT_ACTIVE(act), .SERVO_LOCK(slock),
        .POS_LOOP_EN(plock), .SPEED_MATCH(match), .HOLD_GAIN(gain));
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", nm, exp, seen);
            fail_count++;
        end
    endtask : chk
    task automatic hang_chk(input int n, input int lim);
        if (n >= lim) begin
            fail_count++;
            wrap_up();
        end
    endtask : hang_chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        hang_chk(n, 50);
    endtask : apb
    task automatic go(input logic [2:0] r, input logic signed [15:0] e);
        int n;
        @(posedge clk);
        req <= r;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (cmd !== e && n < 2000);
        hang_chk(n, 2000);
        chk("speed_cmd", 32'(cmd), 32'(e));
        chk("sel_lag", {31'h0, n <= 60}, 32'h1);
    endtask : go
    task automatic t_regs;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, RA[i], 32'h0);
            chk("reg_reset", rd, RV[i]);
        end
        chk("gain_pin", 32'(gain), 32'h28);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped_err", {31'h0, er}, 32'h1);
        chk("unmapped_data", rd, 32'h0);
        apb(1'b1, 8'h14, 32'h1388);
        apb(1'b0, 8'h14, 32'h0);
        chk("preset_clamp", rd, 32'h1194);
        apb(1'b1, 8'h14, 32'h64);
        apb(1'b1, 8'h10, 32'h0);
        apb(1'b1, 8'h10, 32'h1F4);
        $display("done regs");
    endtask : t_regs
    task automatic t_codes;
        @(posedge clk);
        analog <= 16'sh0033;
        go(3'b011, 16'sh0033);
        chk("active", {31'h0, act}, 32'h0);
        apb(1'b1, 8'h04, 32'h4);
        for (int d = 0; d < 2; d++) begin
            for (int k = 0; k < 3; k++) begin
                go({d[0], CD[k]}, d ? 16'sh0000 - PV[k] : PV[k]);
            end
        end
        @(posedge clk);
        actual <= -16'sh0122;
        repeat (4) @(negedge clk);
        chk("match_edge", {31'h0, match}, 32'h1);
        @(posedge clk);
        actual <= -16'sh0121;
        repeat (4) @(negedge clk);
        chk("match_out", {31'h0, match}, 32'h0);
        $display("done codes");
    endtask : t_codes
    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, 8'h00, 32'(m) << 10);
            @(posedge clk);
            analog <= 16'sh004D;
            actual <= 16'sh0032;
            go(3'b010, 16'sh0064);
            go(3'b000, m[1] ? 16'sh004D : 16'sh0000);
            repeat (4) @(negedge clk);
            chk("pos_fast", {31'h0, plock}, 32'h0);
            @(posedge clk);
            actual <= 16'sh0005;
            repeat (4) @(negedge clk);
            chk("holds", {30'h0, slock, plock}, {30'h0, m == 0, m == 1});
        end
        $display("done modes");
    endtask : t_modes
    task automatic t_torque;
        apb(1'b1, 8'h00, 32'h1);
        @(posedge clk);
        analog <= 16'sh0055;
        go(3'b011, 16'sh0055);
        chk("torque_off", {31'h0, act}, 32'h0);
        apb(1'b1, 8'h00, 32'h0);
        $display("done torque");
    endtask : t_torque
    task automatic t_ramp;
        int n;
        apb(1'b1, 8'h24, 32'h384);
        go(3'b001, 16'sh012C);
        @(posedge clk);
        req <= 3'b000;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (cmd === 16'sh012C && n < 100);
        hang_chk(n, 100);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (cmd !== 16'sh0000 && n < 1000);
        hang_chk(n, 1000);
        // 900 ms per 4500 counts at 10 cycles per ms gives two cycles per count
        chk("ramp_len", {31'h0, n >= 590 && n <= 606}, 32'h1);
        repeat (4) @(negedge clk);
        chk("stop_hold", {31'h0, slock}, 32'h1);
        apb(1'b0, 8'h28, 32'h0);
        chk("status", rd, 32'h0000000E);
        $display("done ramp");
    endtask : t_ramp
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_codes();
        t_modes();
        t_torque();
        t_ramp();
        wrap_up();
    end
endmodule : test_internal_speed_selector
`default_nettype wire
